// *** core/spfs_sequencer.sv ***
// self programming flash sequencer: apb registers, keyed mode entry, command engine
// assumes an apb master on CLK, a cpu that pulses HALT_EXEC and obeys CPU_STALL,
// and a flash macro with one-cycle read latency that erases and writes on a pulse
//
// Notes on behaviour
// - halt in self programming mode runs the prepared command, then releases stall itself.
// - maskable interrupt servicing is suppressed while self programming mode is set.
// - internal verify lasts 6.8 ms for a whole block, 27 us per byte otherwise.
// - block erase erases the numbered block and ends 8.5 ms after halt.
// - blank check tests the block for erased bytes and ends 480 us after halt.
// - byte write programs one byte at the pointer and ends 150 us after halt.
// - interrupts during self programming stay latched and are serviced after mode exit.
// - the cpu executes nothing while a command runs; software services the watchdog first.
// - the sequencer never touches ram while a command runs.
// - an erased block reads ff everywhere; erase checks this afterwards.
// - pins keep their halt-mode state during self programming mode.
// - programmer security is ignored; only the protect byte blocks erase or write.
// - the protect byte lives at flash address 081h.
// - mode bit 0 selects normal (0) or self programming (1); cleared at reset.
// - protect byte is loaded into bits 2 to 6 after reset; bits 7, 1 read zero.
// - mode register changes only after key, value, inverse, value, or when an undefined command cancels the mode; last store counts.
// - a broken keyed sequence sets bit 0 of the status register.
// - the key register holds nothing readable after reset.
// - status flags clear only by writing zero or by reset; status resets to 00h.
// - verify failures set the verify flag; protected targets set the protect flag.
// - command codes are verify 001, erase 011, blank check 100, byte write 101.
// - an undefined command with the mode set cancels the mode, runs nothing, flags nothing.
`timescale 1ns/100ps
module spfs_sequencer #(
  parameter int P_CYC_VERIFY_BLOCK = spfs_pkg::CYC_VERIFY_BLOCK,
  parameter int P_CYC_VERIFY_BYTE  = spfs_pkg::CYC_VERIFY_BYTE,
  parameter int P_CYC_ERASE        = spfs_pkg::CYC_ERASE,
  parameter int P_CYC_BLANK        = spfs_pkg::CYC_BLANK,
  parameter int P_CYC_WRITE        = spfs_pkg::CYC_WRITE
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RESETN,
  // apb slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [spfs_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // cpu side
  input  wire logic                        HALT_EXEC,
  output logic                             CPU_STALL,
  output logic                             INT_SUPPRESS,
  output logic                             RAM_BLOCK,
  output logic                             PIN_HOLD,
  // flash macro
  output logic      [11:0]                 FLASH_ADDR,
  output logic      [7:0]                  FLASH_WDATA,
  output logic                             FLASH_RD,
  output logic                             FLASH_ERASE,
  output logic                             FLASH_WRITE,
  input  wire logic [7:0]                  FLASH_RDATA,
  input  wire logic                        FLASH_VFY_FAIL
);
  import spfs_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [15:0] idx;
  logic        mapped;
  logic        wr;
  logic        rd_setup;
  logic [7:0]  wbyte;

  assign idx      = PADDR[ADDR_W-1:2];
  assign mapped   = (idx >= IDX_COMMAND) && (idx <= IDX_WBUF);
  assign wr       = PSEL && PENABLE && PWRITE && mapped;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wbyte    = PWDATA[7:0];
  // registers never insert wait states
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !mapped;

  function automatic logic cmd_valid(input logic [2:0] c);
    cmd_valid = (c == CMD_VERIFY) || (c == CMD_ERASE) || (c == CMD_BLANK) || (c == CMD_WRITE);
  endfunction

  // ----------------------------------------------------------------
  // register file and keyed store sequence
  // ----------------------------------------------------------------
  spfs_key_t  key_state;
  spfs_key_t  next_key_state;
  logic [7:0] key_val;
  logic [7:0] next_key_val;
  logic       mode;
  logic       next_mode;
  logic [4:0] protect;
  logic [4:0] next_protect;
  logic [2:0] command;
  logic [2:0] next_command;
  logic [2:0] status;
  logic [2:0] next_status;
  logic [7:0] aph;
  logic [7:0] next_aph;
  logic [7:0] apl;
  logic [7:0] next_apl;
  logic [7:0] aphc;
  logic [7:0] next_aphc;
  logic [7:0] aplc;
  logic [7:0] next_aplc;
  logic [7:0] wbuf;
  logic [7:0] next_wbuf;
  logic [31:0] next_prdata;
  logic       seq_err;

  // set by the command engine below
  logic       set_vfy;
  logic       set_prot;
  logic       prot_load;

  always_comb begin
    next_key_state = key_state;
    next_key_val   = key_val;
    next_mode      = mode;
    next_protect   = protect;
    next_command   = command;
    next_aph       = aph;
    next_apl       = apl;
    next_aphc      = aphc;
    next_aplc      = aplc;
    next_wbuf      = wbuf;
    next_status    = status;
    seq_err        = 1'b0;
    if (prot_load) begin
      next_protect = FLASH_RDATA[4:0];
    end
    if (wr) begin
      if (idx == IDX_KEY) begin
        // a key write in mid sequence is itself a broken sequence
        seq_err        = (wbyte != KEY_VALUE) || (key_state != KEY_IDLE);
        next_key_state = (wbyte == KEY_VALUE) ? KEY_ARMED : KEY_IDLE;
      end else if (idx == IDX_MODE_CTRL) begin
        next_key_state = KEY_IDLE;
        case (key_state)
          KEY_ARMED: begin
            next_key_val   = wbyte;
            next_key_state = KEY_VALUE_SEEN;
          end
          KEY_VALUE_SEEN: begin
            if (wbyte == ~key_val) begin
              next_key_state = KEY_INVERT_SEEN;
            end else begin
              seq_err = 1'b1;
            end
          end
          KEY_INVERT_SEEN: begin
            if (wbyte == key_val) begin
              next_mode = wbyte[MODE_SEL_BIT];
            end else begin
              seq_err = 1'b1;
            end
          end
          default: begin
            seq_err = 1'b1;
          end
        endcase
      end else begin
        if (key_state != KEY_IDLE) begin
          seq_err        = 1'b1;
          next_key_state = KEY_IDLE;
        end
        case (idx)
          IDX_COMMAND: next_command = wbyte[2:0];
          IDX_STATUS:  next_status  = status & wbyte[2:0];
          IDX_APH:     next_aph     = wbyte;
          IDX_APL:     next_apl     = wbyte;
          IDX_APHC:    next_aphc    = wbyte;
          IDX_APLC:    next_aplc    = wbyte;
          IDX_WBUF:    next_wbuf    = wbyte;
          default:     next_wbuf    = wbuf;
        endcase
      end
    end
    // hardware sets win over a simultaneous software clear
    next_status[ST_SEQ_ERR]  = next_status[ST_SEQ_ERR] | seq_err;
    next_status[ST_VFY_ERR]  = next_status[ST_VFY_ERR] | set_vfy;
    next_status[ST_PROT_ERR] = next_status[ST_PROT_ERR] | set_prot;
    if (next_mode && !cmd_valid(next_command)) begin
      next_mode = 1'b0;
    end
    next_prdata = PRDATA;
    if (rd_setup) begin
      case (idx)
        IDX_COMMAND:   next_prdata = {29'h0, command};
        IDX_STATUS:    next_prdata = {29'h0, status};
        IDX_MODE_CTRL: next_prdata = {25'h0, protect, 1'b0, mode};
        IDX_APH:       next_prdata = {24'h0, aph};
        IDX_APL:       next_prdata = {24'h0, apl};
        IDX_APHC:      next_prdata = {24'h0, aphc};
        IDX_APLC:      next_prdata = {24'h0, aplc};
        IDX_WBUF:      next_prdata = {24'h0, wbuf};
        default:       next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      key_state <= KEY_IDLE;
      key_val   <= BYTE_RST;
      mode      <= 1'b0;
      protect   <= PROTECT_RST;
      command   <= COMMAND_RST;
      status    <= STATUS_RST;
      aph       <= BYTE_RST;
      apl       <= BYTE_RST;
      aphc      <= BYTE_RST;
      aplc      <= BYTE_RST;
      wbuf      <= BYTE_RST;
      PRDATA    <= 32'h0;
    end else begin
      key_state <= next_key_state;
      key_val   <= next_key_val;
      mode      <= next_mode;
      protect   <= next_protect;
      command   <= next_command;
      status    <= next_status;
      aph       <= next_aph;
      apl       <= next_apl;
      aphc      <= next_aphc;
      aplc      <= next_aplc;
      wbuf      <= next_wbuf;
      PRDATA    <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  spfs_seq_t          seq_state;
  spfs_seq_t          next_seq_state;
  logic [2:0]         run_cmd;
  logic [2:0]         next_run_cmd;
  logic               scan_go;
  logic               next_scan_go;
  logic               scan_active;
  logic               next_scan_active;
  logic               rd_pend;
  logic               next_rd_pend;
  logic [11:0]        scan_addr;
  logic [11:0]        next_scan_addr;
  logic [11:0]        scan_end;
  logic [11:0]        next_scan_end;
  logic [11:0]        next_flash_addr;
  logic               next_flash_rd;
  logic               next_flash_erase;
  logic               next_flash_write;
  logic               timer_load;
  logic [TIMER_W-1:0] timer_value;
  logic [TIMER_W-1:0] timer_left;
  logic               timer_done;
  logic [3:0]         blk;
  logic               blk_protected;
  logic [8:0]         nbytes;
  logic               mismatch;

  // only the low nibble of the high pointer selects a block
  assign blk           = aph[3:0];
  // blocks below the protect value are guarded
  assign blk_protected = {1'b0, blk} < protect;
  assign nbytes        = (aplc >= apl) ? ({1'b0, aplc} - {1'b0, apl} + 9'h001) : 9'h001;

  always_comb begin
    case (run_cmd)
      CMD_VERIFY: mismatch = FLASH_VFY_FAIL;
      CMD_WRITE:  mismatch = FLASH_RDATA != wbuf;
      default:    mismatch = FLASH_RDATA != ERASED_BYTE;
    endcase
  end

  always_comb begin
    next_seq_state   = seq_state;
    next_run_cmd     = run_cmd;
    next_scan_go     = scan_go;
    next_scan_active = scan_active;
    next_rd_pend     = 1'b0;
    next_scan_addr   = scan_addr;
    next_scan_end    = scan_end;
    next_flash_addr  = FLASH_ADDR;
    next_flash_rd    = 1'b0;
    next_flash_erase = 1'b0;
    next_flash_write = 1'b0;
    timer_load       = 1'b0;
    timer_value      = '0;
    set_vfy          = 1'b0;
    set_prot         = 1'b0;
    prot_load        = 1'b0;
    case (seq_state)
      SEQ_BOOT: begin
        next_flash_addr = PROTECT_BYTE_ADDR;
        next_flash_rd   = 1'b1;
        next_seq_state  = SEQ_BOOT_WAIT;
      end
      SEQ_BOOT_WAIT: begin
        if (!FLASH_RD) begin
          prot_load      = 1'b1;
          next_seq_state = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
        if (HALT_EXEC && mode) begin
          next_seq_state = SEQ_RUN;
          next_run_cmd   = command;
          timer_load     = 1'b1;
          next_scan_go   = 1'b1;
          next_scan_addr = {blk, BLOCK_FIRST};
          next_scan_end  = {blk, BLOCK_LAST};
          case (command)
            CMD_VERIFY: begin
              next_scan_addr = {blk, apl};
              next_scan_end  = {blk, aplc};
              if (apl == BLOCK_FIRST && aplc == BLOCK_LAST) begin
                timer_value = TIMER_W'(P_CYC_VERIFY_BLOCK);
              end else begin
                timer_value = TIMER_W'(nbytes * P_CYC_VERIFY_BYTE);
              end
            end
            CMD_ERASE: begin
              timer_value = TIMER_W'(P_CYC_ERASE);
              if (blk_protected) begin
                set_prot     = 1'b1;
                next_scan_go = 1'b0;
              end else begin
                next_flash_addr  = {blk, BLOCK_FIRST};
                next_flash_erase = 1'b1;
              end
            end
            CMD_BLANK: begin
              timer_value = TIMER_W'(P_CYC_BLANK);
            end
            default: begin
              timer_value    = TIMER_W'(P_CYC_WRITE);
              next_scan_addr = {blk, apl};
              next_scan_end  = {blk, apl};
              if (blk_protected) begin
                set_prot     = 1'b1;
                next_scan_go = 1'b0;
              end else begin
                next_flash_addr  = {blk, apl};
                next_flash_write = 1'b1;
              end
            end
          endcase
        end
      end
      SEQ_RUN: begin
        next_rd_pend = FLASH_RD;
        // readback happens in the tail of the timed window, so the end time stays exact
        if (scan_go && timer_left == SCAN_RESERVE) begin
          next_scan_active = 1'b1;
          next_scan_go     = 1'b0;
        end
        if (scan_active) begin
          next_flash_addr = scan_addr;
          next_flash_rd   = 1'b1;
          if (scan_addr == scan_end) begin
            next_scan_active = 1'b0;
          end else begin
            next_scan_addr = scan_addr + 12'h001;
          end
        end
        if (rd_pend && mismatch) begin
          set_vfy = 1'b1;
        end
        if (timer_done) begin
          next_seq_state   = SEQ_IDLE;
          next_scan_active = 1'b0;
          next_scan_go     = 1'b0;
        end
      end
      default: begin
        next_seq_state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      seq_state   <= SEQ_BOOT;
      run_cmd     <= COMMAND_RST;
      scan_go     <= 1'b0;
      scan_active <= 1'b0;
      rd_pend     <= 1'b0;
      scan_addr   <= 12'h000;
      scan_end    <= 12'h000;
      FLASH_ADDR  <= 12'h000;
      FLASH_RD    <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
    end else begin
      seq_state   <= next_seq_state;
      run_cmd     <= next_run_cmd;
      scan_go     <= next_scan_go;
      scan_active <= next_scan_active;
      rd_pend     <= next_rd_pend;
      scan_addr   <= next_scan_addr;
      scan_end    <= next_scan_end;
      FLASH_ADDR  <= next_flash_addr;
      FLASH_RD    <= next_flash_rd;
      FLASH_ERASE <= next_flash_erase;
      FLASH_WRITE <= next_flash_write;
    end
  end

  spfs_timer u_timer (
    .clk        (CLK),
    .resetn     (RESETN),
    .load       (timer_load),
    .load_value (timer_value),
    .remaining  (timer_left),
    .done       (timer_done)
  );

  // ----------------------------------------------------------------
  // cpu side levels
  // ----------------------------------------------------------------
  // the cpu stays held until the protect byte is known after reset
  assign CPU_STALL    = (seq_state != SEQ_IDLE);
  assign RAM_BLOCK    = (seq_state == SEQ_RUN);
  assign INT_SUPPRESS = mode;
  assign PIN_HOLD     = mode;
  assign FLASH_WDATA  = wbuf;

endmodule

// *** core/spfs_pkg.sv ***
// package for the self programming flash sequencer
// assumes a 100 MHz system clock and a byte-wide flash macro behind the block
package spfs_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 18;
  localparam logic [15:0] IDX_COMMAND   = 16'hffa0;
  localparam logic [15:0] IDX_STATUS    = 16'hffa1;
  localparam logic [15:0] IDX_MODE_CTRL = 16'hffa2;
  localparam logic [15:0] IDX_KEY       = 16'hffa3;
  localparam logic [15:0] IDX_APH       = 16'hffa4;
  localparam logic [15:0] IDX_APL       = 16'hffa5;
  localparam logic [15:0] IDX_APHC      = 16'hffa6;
  localparam logic [15:0] IDX_APLC      = 16'hffa7;
  localparam logic [15:0] IDX_WBUF      = 16'hffa8;

  // ----------------------------------------------------------------
  // field positions, key and reset values
  // ----------------------------------------------------------------
  localparam int         MODE_SEL_BIT      = 0;
  localparam int         PROT_LSB          = 2;
  localparam int         ST_SEQ_ERR        = 0;
  localparam int         ST_VFY_ERR        = 1;
  localparam int         ST_PROT_ERR       = 2;
  localparam logic [7:0] KEY_VALUE         = 8'ha5;
  localparam logic [7:0] ERASED_BYTE       = 8'hff;
  localparam logic [11:0] PROTECT_BYTE_ADDR = 12'h081;
  localparam logic [2:0] STATUS_RST        = 3'h0;
  localparam logic [2:0] COMMAND_RST       = 3'h0;
  localparam logic [4:0] PROTECT_RST       = 5'h00;
  localparam logic [7:0] BYTE_RST          = 8'h00;
  localparam logic [7:0] BLOCK_FIRST       = 8'h00;
  localparam logic [7:0] BLOCK_LAST        = 8'hff;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_VERIFY = 3'h1;
  localparam logic [2:0] CMD_ERASE  = 3'h3;
  localparam logic [2:0] CMD_BLANK  = 3'h4;
  localparam logic [2:0] CMD_WRITE  = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 100;
  localparam int T_VERIFY_BLOCK_NS  = 6800000;
  localparam int T_VERIFY_BYTE_NS   = 27000;
  localparam int T_ERASE_NS         = 8500000;
  localparam int T_BLANK_NS         = 480000;
  localparam int T_WRITE_NS         = 150000;
  localparam int CYC_VERIFY_BLOCK   = T_VERIFY_BLOCK_NS * CLK_MHZ / 1000;
  localparam int CYC_VERIFY_BYTE    = T_VERIFY_BYTE_NS * CLK_MHZ / 1000;
  localparam int CYC_ERASE          = T_ERASE_NS * CLK_MHZ / 1000;
  localparam int CYC_BLANK          = T_BLANK_NS * CLK_MHZ / 1000;
  localparam int CYC_WRITE          = T_WRITE_NS * CLK_MHZ / 1000;
  localparam int TIMER_W            = 20;
  localparam logic [19:0] SCAN_RESERVE = 20'h00104;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_VALUE_SEEN, KEY_INVERT_SEEN} spfs_key_t;
  typedef enum logic [1:0] {SEQ_BOOT, SEQ_BOOT_WAIT, SEQ_IDLE, SEQ_RUN} spfs_seq_t;

endpackage

// *** core/spfs_timer.sv ***
// down counter that times one sequencer command
// assumes load is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/100ps
module spfs_timer (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // control
  input  wire logic                          load,
  input  wire logic [spfs_pkg::TIMER_W-1:0]  load_value,
  // status
  output logic      [spfs_pkg::TIMER_W-1:0]  remaining,
  output logic                               done
);
  import spfs_pkg::*;

  logic [TIMER_W-1:0] count;
  logic [TIMER_W-1:0] next_count;
  logic               next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
      // done stands in the last counted cycle, so a run lasts exactly the loaded count
      next_done  = (next_count == 20'h00001);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

  assign remaining = count;

endmodule

// *** testbench/spfs_monitor.sv ***
// checker on the sequencer ports
// assumes a bind onto spfs_sequencer and one clock
`timescale 1ns/100ps
module spfs_monitor (
  // clock, reset and apb
  input wire logic                        CLK,
  input wire logic                        RESETN,
  input wire logic                        PSEL,
  input wire logic                        PENABLE,
  input wire logic                        PWRITE,
  input wire logic [spfs_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0]                 PRDATA,
  // cpu and flash side
  input wire logic                        HALT_EXEC,
  input wire logic                        CPU_STALL,
  input wire logic                        INT_SUPPRESS,
  input wire logic                        RAM_BLOCK,
  input wire logic                        PIN_HOLD,
  input wire logic                        FLASH_ERASE,
  input wire logic                        FLASH_WRITE
);
  import spfs_pkg::*;
  logic mode_wr;
  logic mode_rd;
  assign mode_wr = PSEL && PENABLE && PWRITE && PADDR[17:2] == IDX_MODE_CTRL;
  assign mode_rd = PSEL && PENABLE && !PWRITE && PADDR[17:2] == IDX_MODE_CTRL;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence halt_on; HALT_EXEC && INT_SUPPRESS && !CPU_STALL; endsequence
  sequence halt_off; HALT_EXEC && !INT_SUPPRESS && !CPU_STALL; endsequence
  halt_stall_a: assert property (halt_on |=> CPU_STALL && RAM_BLOCK)
    else $error("no stall after halt");
  halt_ignored_a: assert property (halt_off |=> !CPU_STALL)
    else $error("halt ran in normal mode");
  mask_pins_a: assert property (PIN_HOLD == INT_SUPPRESS)
    else $error("pin hold differs from mask");
  ram_stall_a: assert property (RAM_BLOCK |-> CPU_STALL)
    else $error("ram blocked without stall");
  prog_pulse_a: assert property (FLASH_ERASE || FLASH_WRITE |-> RAM_BLOCK)
    else $error("flash pulse outside command");
  cmd_span_a: assert property ($rose(RAM_BLOCK) |-> RAM_BLOCK [*8])
    else $error("command ended early");
  mode_key_a: assert property ($rose(INT_SUPPRESS) |-> $past(mode_wr))
    else $error("mode set without store");
  ro_bits_a: assert property (mode_rd |-> PRDATA[7] == 1'b0 && PRDATA[1] == 1'b0)
    else $error("mode reserved bits set");
endmodule

// *** testbench/spfs_flash_model.sv ***
// behavioural flash macro
// assumes one-cycle read latency and pulsed erase and write
`timescale 1ns/100ps
module spfs_flash_model (
  // clock
  input  wire logic        clk,
  // sequencer side
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd,
  input  wire logic        erase,
  input  wire logic        write,
  output logic      [7:0]  rdata,
  output logic             vfy_fail
);
  logic [7:0] mem [4096];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[12'h081] = 8'h02;
    rdata = 8'h00;
    vfy_fail = 1'b0;
  end
  always @(posedge clk) begin
    // unrequested cycles show a toggling value, not the last byte
    rdata <= rd ? mem[addr] : ~rdata;
    // never programmed bytes fail the margin read
    vfy_fail <= rd && mem[addr] == 8'h00;
    if (erase) for (int i = 0; i < 256; i++) mem[{addr[11:8], i[7:0]}] <= 8'hff;
    if (write) mem[addr] <= wdata;
  end
endmodule

// *** testbench/tb_top.sv ***
// testbench for the sequencer
// assumes the flash model and the checker; command counts shortened
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  import spfs_pkg::*;
  localparam int VB = 700, VY = 610, ER = 800, BL = 650, WR = 620;
  logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, HALT_EXEC = 0, err;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic PREADY, PSLVERR, CPU_STALL, INT_SUPPRESS, RAM_BLOCK, PIN_HOLD, F_RD, F_ER, F_WR, F_VF;
  logic [11:0] F_A;
  logic [7:0] F_WD, F_RDAT;
  int errors = 0, n_compared = 0;
  spfs_sequencer #(.P_CYC_VERIFY_BLOCK(VB), .P_CYC_VERIFY_BYTE(VY), .P_CYC_ERASE(ER),
    .P_CYC_BLANK(BL), .P_CYC_WRITE(WR)) spfs_sequencer_inst (.CLK(CLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HALT_EXEC(HALT_EXEC),
    .CPU_STALL(CPU_STALL), .INT_SUPPRESS(INT_SUPPRESS), .RAM_BLOCK(RAM_BLOCK), .PIN_HOLD(PIN_HOLD),
    .FLASH_ADDR(F_A), .FLASH_WDATA(F_WD), .FLASH_RD(F_RD), .FLASH_ERASE(F_ER),
    .FLASH_WRITE(F_WR), .FLASH_RDATA(F_RDAT), .FLASH_VFY_FAIL(F_VF));
  spfs_flash_model spfs_flash_model_inst (.clk(CLK), .addr(F_A), .wdata(F_WD), .rd(F_RD),
    .erase(F_ER), .write(F_WR), .rdata(F_RDAT), .vfy_fail(F_VF));
  always #5 CLK = ~CLK;
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 50);
    if (n >= 50) errors++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    apb(0, idx, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic keyed(input logic [7:0] v);
    apb(1, IDX_KEY, KEY_VALUE);
    apb(1, IDX_MODE_CTRL, v);
    apb(1, IDX_MODE_CTRL, ~v);
    apb(1, IDX_MODE_CTRL, v);
    repeat (1600) @(posedge CLK);
  endtask
  task automatic run(input int e);
    int n;
    n = 0;
    @(posedge CLK);
    HALT_EXEC <= 1;
    @(posedge CLK);
    HALT_EXEC <= 0;
    #1;
    while (CPU_STALL === 1'b1 && n < 20000) begin
      n++;
      @(posedge CLK);
      #1;
    end
    `CHK(n, e)
  endtask
  task automatic ptrs(input logic [7:0] h, input logic [7:0] l, input logic [7:0] lc);
    apb(1, IDX_APH, h);
    apb(1, IDX_APHC, h);
    apb(1, IDX_APL, l);
    apb(1, IDX_APLC, lc);
  endtask
  task automatic t_reset;
    rchk(IDX_MODE_CTRL, 8'h08);
    rchk(IDX_STATUS, 8'h00);
    rchk(IDX_KEY, 8'h00);
    apb(0, 16'h0010, 8'h00);
    `CHK(err, 1'b1)
  endtask
  task automatic t_key;
    apb(1, IDX_MODE_CTRL, 8'h01);
    rchk(IDX_STATUS, 8'h01);
    apb(1, IDX_STATUS, 8'h00);
    rchk(IDX_STATUS, 8'h00);
    apb(1, IDX_KEY, KEY_VALUE);
    apb(1, IDX_MODE_CTRL, 8'h01);
    apb(1, IDX_MODE_CTRL, 8'h01);
    rchk(IDX_STATUS, 8'h01);
    rchk(IDX_MODE_CTRL, 8'h08);
    apb(1, IDX_STATUS, 8'h00);
    apb(1, IDX_COMMAND, CMD_ERASE);
    keyed(8'h01);
    rchk(IDX_MODE_CTRL, 8'h09);
    `CHK(INT_SUPPRESS, 1'b1)
    `CHK(PIN_HOLD, 1'b1)
  endtask
  task automatic t_cmds;
    logic [2:0] c [4] = '{CMD_ERASE, CMD_BLANK, CMD_WRITE, CMD_VERIFY};
    int t [4] = '{ER, BL, WR, VB};
    apb(1, IDX_WBUF, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      ptrs(8'h03, 8'h00, 8'hff);
      apb(1, IDX_COMMAND, c[i]);
      run(t[i]);
    end
    ptrs(8'h03, 8'h10, 8'h12);
    run(3 * VY);
    `CHK(spfs_flash_model_inst.mem[12'h300], 8'h5a)
    `CHK(spfs_flash_model_inst.mem[12'h3ff], 8'hff)
    rchk(IDX_STATUS, 8'h00);
  endtask
  task automatic t_errors;
    ptrs(8'h04, 8'h00, 8'hff);
    apb(1, IDX_COMMAND, CMD_VERIFY);
    run(VB);
    rchk(IDX_STATUS, 8'h02);
    apb(1, IDX_STATUS, 8'h00);
    apb(1, IDX_COMMAND, CMD_BLANK);
    run(BL);
    ptrs(8'h01, 8'h00, 8'hff);
    apb(1, IDX_COMMAND, CMD_ERASE);
    run(ER);
    rchk(IDX_STATUS, 8'h06);
    `CHK(spfs_flash_model_inst.mem[12'h100], 8'h00)
    apb(1, IDX_STATUS, 8'h00);
    rchk(IDX_STATUS, 8'h00);
  endtask
  task automatic t_undef;
    keyed(8'h00);
    `CHK(INT_SUPPRESS, 1'b0)
    run(0);
    apb(1, IDX_COMMAND, 8'h07);
    keyed(8'h01);
    rchk(IDX_MODE_CTRL, 8'h08);
    rchk(IDX_STATUS, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RESETN <= 1;
    repeat (4) @(posedge CLK);
    t_reset;
    t_key;
    t_cmds;
    t_errors;
    t_undef;
    end_sim;
  end
  initial begin
    #400000;
    errors++;
    end_sim;
  end
endmodule
bind spfs_sequencer spfs_monitor spfs_monitor_inst (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .HALT_EXEC(HALT_EXEC),
  .CPU_STALL(CPU_STALL), .INT_SUPPRESS(INT_SUPPRESS), .RAM_BLOCK(RAM_BLOCK), .PIN_HOLD(PIN_HOLD),
  .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE));
